// *** hdl/cltx_pkg.sv ***
// package of constants and types for the converter link transmit port set
// ==========================================================================
package cltx_pkg;
  localparam int unsigned LANES        = 2;
  localparam int unsigned WORD_W       = 64;
  localparam int unsigned HDR_W        = 2;
  localparam int unsigned FLAG_W       = 4;
  localparam int unsigned CMD_W        = 19;
  localparam int unsigned CMD_CRC_W    = 7;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned BLK_PER_MB   = 32;   // blocks (cycles) per multi-block
  localparam int unsigned MB_PER_EMB   = 4;    // multi-blocks per extended multi-block
  localparam int unsigned EMB_LEN      = BLK_PER_MB * MB_PER_EMB;
  localparam int unsigned RST_REQ_CYC  = 4;    // cycles the reset request is held
  localparam logic [1:0]  HDR_DATA     = 2'h1; // sync header for a data block
  localparam logic [1:0]  HDR_CMD      = 2'h2; // sync header carrying command bit
  localparam logic [3:0]  FLAGS_NONE   = 4'h0;
  typedef enum logic [1:0] {ST_RESET, ST_WAIT_PHY, ST_SYNC, ST_RUN} cltx_state_e;
endpackage : cltx_pkg

// *** hdl/cltx_link_if.sv ***
// interface joining the transmit core to the sample source and physical layer
`timescale 1ns/10ps
interface cltx_link_if;
  import cltx_pkg::*;
  logic [LANES*WORD_W-1:0] payloadData;
  logic                    payloadReady;
  logic                    embMarker;
  logic [LANES*CMD_W-1:0]  cmdData;
  logic                    cmdValid;
  logic                    cmdReady;
  logic                    streamRst_n;
  logic                    phyResetReq;
  logic                    phyResetDone;
  logic                    sysref;
  logic                    syncReq_n;
  logic [LANES*WORD_W-1:0] laneWordOut;
  logic [LANES*HDR_W-1:0]  laneSyncHeaderOut;
  logic [LANES*FLAG_W-1:0] laneControlCharFlags;
  modport core (input payloadData, cmdData, cmdValid, phyResetDone, sysref, syncReq_n,
                output payloadReady, embMarker, cmdReady, streamRst_n, phyResetReq,
                laneWordOut, laneSyncHeaderOut, laneControlCharFlags);
  modport partner (output payloadData, cmdData, cmdValid, phyResetDone, sysref, syncReq_n,
                   input payloadReady, embMarker, cmdReady, streamRst_n, phyResetReq,
                   laneWordOut, laneSyncHeaderOut, laneControlCharFlags);
endinterface : cltx_link_if

// *** hdl/cltx_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module cltx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // handshakes on each side
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cltx_fifo

// *** hdl/cltx_core.sv ***
// transmit core end: reset handshake, sysref alignment, lane word generation
`timescale 1ns/10ps
module cltx_core
  import cltx_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  cmdModeMeta,  // 1: full 19-bit command, 0: crc meta mode
  input  wire logic  subclass1,
  input  wire logic  coding8b10b,
  output logic       linkUp,
  cltx_link_if.core  lnk
);
  // ==========================================================================
  // state and counters
  cltx_state_e      state_q;
  logic [2:0]       rstCnt_q;
  logic [6:0]       blkCnt_q;       // position inside the extended multi-block
  logic             sysrefSeen_q;
  logic             streamRst_n_q;
  logic             phyResetReq_q;
  logic             payloadReady_q;
  logic             embMarker_q;
  logic             cmdReady_q;
  logic             linkUp_q;
  logic [LANES*WORD_W-1:0] word_q;
  logic [LANES*HDR_W-1:0]  hdr_q;
  logic [LANES*FLAG_W-1:0] flag_q;
  logic [LANES*CMD_W-1:0]  cmdHold_q;
  logic [LANES*CMD_W-1:0]  cmdMasked;
  logic             sysrefRise;
  logic             sysref_q;

  // ==========================================================================
  // reset sequence with the physical layer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q       <= ST_RESET;
      rstCnt_q      <= '0;
      phyResetReq_q <= 1'b1;
      streamRst_n_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          rstCnt_q <= rstCnt_q + 3'h1;
          if (rstCnt_q == 3'(RST_REQ_CYC - 1)) begin
            phyResetReq_q <= 1'b0;
            state_q       <= ST_WAIT_PHY;
          end
        end
        ST_WAIT_PHY: begin
          if (lnk.phyResetDone) begin
            streamRst_n_q <= 1'b1;
            state_q       <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (!coding8b10b || lnk.syncReq_n) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (coding8b10b && !lnk.syncReq_n) begin
            state_q <= ST_SYNC;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // sysref edge detection and extended multi-block phase
  assign sysrefRise = lnk.sysref && !sysref_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysref_q     <= 1'b0;
      sysrefSeen_q <= 1'b0;
      blkCnt_q     <= '0;
    end else begin
      sysref_q <= lnk.sysref;
      if (subclass1 && sysrefRise) begin
        blkCnt_q     <= '0;
        sysrefSeen_q <= 1'b1;
      end else begin
        blkCnt_q <= (blkCnt_q == 7'(EMB_LEN - 1)) ? '0 : blkCnt_q + 7'h1;
      end
    end
  end

  // ==========================================================================
  // stream handshakes: payload ready every cycle, command ready once per multi-block, marker one cycle ahead
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      payloadReady_q <= 1'b0;
      embMarker_q    <= 1'b0;
      cmdReady_q     <= 1'b0;
      linkUp_q       <= 1'b0;
    end else begin
      linkUp_q       <= (state_q == ST_RUN) && (!subclass1 || sysrefSeen_q);
      payloadReady_q <= (state_q == ST_RUN) && (!subclass1 || sysrefSeen_q);
      // blkCnt_q+1 is the count seen while the next accepted word is presented
      embMarker_q    <= (blkCnt_q == 7'(EMB_LEN - 2))
                        && !(subclass1 && sysrefRise);
      cmdReady_q     <= (state_q == ST_RUN)
                        && (blkCnt_q[4:0] == 5'(BLK_PER_MB - 2));
    end
  end

  // ==========================================================================
  // command word masking by meta mode
  always_comb begin
    cmdMasked = lnk.cmdData;
    for (int i = 0; i < LANES; i++) begin
      if (!cmdModeMeta) begin
        cmdMasked[i*CMD_W+CMD_CRC_W +: CMD_W-CMD_CRC_W] = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdHold_q <= '0;
    end else if (lnk.cmdValid && cmdReady_q) begin
      cmdHold_q <= cmdMasked;
    end
  end

  // ==========================================================================
  // lane outputs to the physical layer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q <= '0;
      hdr_q  <= '0;
      flag_q <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        word_q[i*WORD_W +: WORD_W] <= payloadReady_q ? lnk.payloadData[i*WORD_W +: WORD_W]
                                                     : '0;
        hdr_q[i*HDR_W +: HDR_W]    <= cmdHold_q[i*CMD_W + 5'(blkCnt_q[4:0] % 5'(CMD_W))]
                                      ? HDR_CMD : HDR_DATA;
        flag_q[i*FLAG_W +: FLAG_W] <= FLAGS_NONE;
      end
    end
  end

  assign lnk.streamRst_n          = streamRst_n_q;
  assign lnk.phyResetReq          = phyResetReq_q;
  assign lnk.payloadReady         = payloadReady_q;
  assign lnk.embMarker            = embMarker_q;
  assign lnk.cmdReady             = cmdReady_q;
  assign lnk.laneWordOut          = word_q;
  assign lnk.laneSyncHeaderOut    = hdr_q;
  assign lnk.laneControlCharFlags = flag_q;
  assign linkUp                   = linkUp_q;
endmodule : cltx_core

// *** hdl/cltx_partner.sv ***
// partner end: sample source with fifo and physical-layer reset responder
`timescale 1ns/10ps
module cltx_partner
  import cltx_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [LANES*WORD_W-1:0] sampleData,
  input  wire logic                    sampleValid,
  output logic                         sampleReady,
  input  wire logic [LANES*CMD_W-1:0]  userCmd,
  input  wire logic                    userCmdValid,
  input  wire logic                    cmdModeMeta,
  input  wire logic                    sysrefIn,
  input  wire logic                    syncIn_n,
  output logic                         cmdTaken,
  output logic                         underrun,
  cltx_link_if.partner                 lnk
);
  logic [LANES*WORD_W-1:0] fifoData;
  logic                    fifoValid;
  logic                    phyDone_q;
  logic                    sysref_q;
  logic                    sync_n_q;
  logic                    cmdTaken_q;
  logic                    underrun_q;
  logic [LANES*CMD_W-1:0]  cmdOut;

  // ==========================================================================
  // sample buffer drained by the core's ready
  cltx_fifo #(.WIDTH(LANES*WORD_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (lnk.payloadReady)
  );
  assign lnk.payloadData = fifoValid ? fifoData : '0;

  // ==========================================================================
  // command words, upper bits cleared in crc mode
  always_comb begin
    cmdOut = userCmd;
    for (int i = 0; i < LANES; i++) begin
      if (!cmdModeMeta) begin
        cmdOut[i*CMD_W+CMD_CRC_W +: CMD_W-CMD_CRC_W] = '0;
      end
    end
  end
  assign lnk.cmdData  = cmdOut;
  assign lnk.cmdValid = userCmdValid;

  // ==========================================================================
  // physical layer reset completion and timing reference
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phyDone_q  <= 1'b0;
      sysref_q   <= 1'b0;
      sync_n_q   <= 1'b0;
      cmdTaken_q <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      phyDone_q  <= !lnk.phyResetReq && lnk.streamRst_n == 1'b0 ? 1'b1
                    : (lnk.phyResetReq ? 1'b0 : phyDone_q);
      sysref_q   <= sysrefIn;
      sync_n_q   <= syncIn_n;
      cmdTaken_q <= userCmdValid && lnk.cmdReady;
      underrun_q <= lnk.payloadReady && !fifoValid;
    end
  end
  assign lnk.phyResetDone = phyDone_q;
  assign lnk.sysref       = sysref_q;
  assign lnk.syncReq_n    = sync_n_q;
  assign cmdTaken         = cmdTaken_q;
  assign underrun         = underrun_q;
endmodule : cltx_partner

// *** dv/cltx_link_properties.sv ***
// concurrent checks on the signals joining the two link ends
`timescale 1ns/10ps
module cltx_link_properties
  import cltx_pkg::*;
(
  input logic                    clk,
  input logic                    sys_rst,
  input logic [LANES*WORD_W-1:0] payloadData,
  input logic                    payloadReady,
  input logic                    embMarker,
  input logic [LANES*CMD_W-1:0]  cmdData,
  input logic                    cmdValid,
  input logic                    cmdReady,
  input logic                    streamRst_n,
  input logic                    phyResetReq,
  input logic                    phyResetDone,
  input logic [LANES*WORD_W-1:0] laneWordOut,
  input logic [LANES*HDR_W-1:0]  laneSyncHeaderOut,
  input logic [LANES*FLAG_W-1:0] laneControlCharFlags
);
  // ====================
  // sequences
  // marker cycle followed by the accepted block-start word
  sequence sEmbStart;
    embMarker ##1 payloadReady;
  endsequence
  // command offered but not yet taken
  sequence sCmdStall;
    cmdValid && !cmdReady;
  endsequence
  // every lane carries either a data header or a command-bit header
  logic hdrLegal;
  assign hdrLegal = (laneSyncHeaderOut[HDR_W-1:0] inside {HDR_DATA, HDR_CMD})
                    && (laneSyncHeaderOut[2*HDR_W-1:HDR_W] inside {HDR_DATA, HDR_CMD});
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ====================
  // properties
  AST_RST_REQ_HOLD: assert property ($fell(sys_rst) |-> phyResetReq[*3] ##[1:2] !phyResetReq)
    else $error("reset request length wrong");
  AST_DONE_FIRST: assert property ($rose(streamRst_n) |-> phyResetDone && !phyResetReq)
    else $error("stream reset left before phy done");
  AST_STREAM_QUIET: assert property (!streamRst_n |-> !payloadReady && !cmdReady)
    else $error("ready while stream reset");
  AST_READY_GATE: assert property (payloadReady |-> phyResetDone && streamRst_n)
    else $error("payload taken before phy done");
  AST_LANE_WORD: assert property (payloadReady |=> laneWordOut == $past(payloadData))
    else $error("lane word differs from taken payload");
  AST_FLAGS_ZERO: assert property (payloadReady |=> laneControlCharFlags == '0)
    else $error("control flags set");
  AST_HDR_LEGAL: assert property (streamRst_n |-> hdrLegal)
    else $error("lane sync header not a legal code");
  AST_EMB_PERIOD: assert property (sEmbStart |-> ##127 (embMarker || !payloadReady))
    else $error("marker period wrong");
  AST_CMD_PERIOD: assert property (cmdReady |-> ##32 (cmdReady || !payloadReady))
    else $error("command ready period wrong");
  AST_CMD_SINGLE: assert property (cmdReady |=> (!cmdReady)[*8])
    else $error("command ready longer than one cycle");
  AST_CMD_HOLD: assert property (sCmdStall |=> cmdValid && $stable(cmdData))
    else $error("command dropped before taken");
endmodule // cltx_link_properties

// *** dv/converter_link_tx_port_set_tb.sv ***
// self-checking bench for the two link ends joined through the interface
`timescale 1ns/10ps
module converter_link_tx_port_set_tb
  import cltx_pkg::*;
;
  logic                    clk, sys_rst, cmdModeMeta, subclass1, coding8b10b;
  logic                    sampleValid, userCmdValid, sysrefIn, syncIn_n;
  logic                    linkUp, sampleReady, cmdTaken, underrun;
  logic [LANES*WORD_W-1:0] sampleData;
  logic [LANES*CMD_W-1:0]  userCmd;
  int                      fails = 0, total_checks = 0, cycles = 0, n, k, m, u;
  // ====================
  // ends and checker
  cltx_link_if lnk ();
  cltx_core cltx_core_inst (.clk(clk), .sys_rst(sys_rst), .cmdModeMeta(cmdModeMeta),
    .subclass1(subclass1), .coding8b10b(coding8b10b), .linkUp(linkUp), .lnk(lnk.core));
  cltx_partner cltx_partner_inst (.clk(clk), .sys_rst(sys_rst), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .userCmd(userCmd),
    .userCmdValid(userCmdValid), .cmdModeMeta(cmdModeMeta), .sysrefIn(sysrefIn),
    .syncIn_n(syncIn_n), .cmdTaken(cmdTaken), .underrun(underrun), .lnk(lnk.partner));
  cltx_link_properties props (.clk(clk), .sys_rst(sys_rst), .payloadData(lnk.payloadData),
    .payloadReady(lnk.payloadReady), .embMarker(lnk.embMarker), .cmdData(lnk.cmdData),
    .cmdValid(lnk.cmdValid), .cmdReady(lnk.cmdReady), .streamRst_n(lnk.streamRst_n),
    .phyResetReq(lnk.phyResetReq), .phyResetDone(lnk.phyResetDone),
    .laneWordOut(lnk.laneWordOut), .laneSyncHeaderOut(lnk.laneSyncHeaderOut),
    .laneControlCharFlags(lnk.laneControlCharFlags));
  // ====================
  // clock and hang guard
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  // ====================
  // helpers
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic sig(input int sel);
    case (sel)
      0: return lnk.phyResetReq;
      1: return lnk.streamRst_n;
      2: return lnk.payloadReady;
      default: return lnk.cmdReady & lnk.cmdValid;
    endcase
  endfunction
  // waits at falling edges, counting them in n
  task automatic waitSig(input int sel, input logic val, input int lim);
    n = 0;
    while (sig(sel) !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic logic [127:0] word(input int i);
    return {64'hA000_0000_0000_0000 + 64'(i), 64'h5000_0000_0000_0000 + 64'(i)};
  endfunction
  // ====================
  // tests
  initial begin
    {sys_rst, subclass1, syncIn_n} = 3'h7;
    {cmdModeMeta, coding8b10b, sampleValid, userCmdValid, sysrefIn} = '0;
    sampleData = '0;
    userCmd = '0;
    repeat (4) @(negedge clk);
    check(lnk.phyResetReq, 1);
    check(lnk.streamRst_n, 0);
    sys_rst = 0;
    waitSig(0, 0, 20);
    check(n, RST_REQ_CYC);
    waitSig(1, 1, 20);
    check(n, 2);
    $display("test reset done");
    repeat (3) @(negedge clk);
    check(lnk.payloadReady, 0);
    n = 0;
    sampleValid = 1;
    repeat (10) begin
      sampleData = word(n);
      k = (sampleReady === 1'b1);
      @(negedge clk);
      n += k;
    end
    sampleValid = 0;
    check(n, FIFO_DEPTH);
    sysrefIn = 1;
    @(negedge clk);
    sysrefIn = 0;
    {n, k, m, u} = '0;
    for (int c = 0; c < 300; c++) begin
      @(negedge clk);
      if (n < FIFO_DEPTH && lnk.laneWordOut === word(n)) n++;
      if (underrun === 1'b1) u = 1;
      if (lnk.embMarker === 1'b1) begin
        k = c - m;
        m = c;
      end
    end
    check(n, FIFO_DEPTH);
    check(k, EMB_LEN);
    check(u, 1);
    check(linkUp, 1);
    $display("test payload done");
    for (int md = 0; md < 2; md++) begin
      cmdModeMeta = md[0];
      userCmdValid = 1;
      for (int j = 0; j < 2; j++) begin
        userCmd = {2{19'h7_FF80 + 19'(j)}};
        waitSig(3, 1, 40);
        check(lnk.cmdData, md ? userCmd : userCmd & {2{19'h0_007F}});
        if (j == 1) check(n, BLK_PER_MB - 1);
        if (j == 1 && md == 0) check(lnk.laneSyncHeaderOut, {2{HDR_DATA}});
        @(negedge clk);
        check(cmdTaken, 1);
      end
    end
    userCmdValid = 0;
    $display("test command done");
    {sys_rst, coding8b10b, subclass1, syncIn_n} = 4'hC;
    #1 check(lnk.phyResetReq, 1);
    check(lnk.payloadReady, 0);
    @(negedge clk);
    sys_rst = 0;
    repeat (20) @(negedge clk);
    check(lnk.payloadReady, 0);
    syncIn_n = 1;
    waitSig(2, 1, 50);
    check(lnk.payloadReady, 1);
    syncIn_n = 0;
    waitSig(2, 0, 10);
    check(lnk.payloadReady, 0);
    $display("test sync done");
    wrap_up();
  end
endmodule // converter_link_tx_port_set_tb
